// ---- rtl/prdmc_pkg.sv ----
// Summary of operation
// - Decode RF word: boost, sleep, prescaler, counts.
// - Single-loop lock: pin high, narrow low pulses.
// - Combined lock only when both loops locked.
// - IF counter reset clears dividers, floats pump.
// - RF counter reset clears dividers, floats pump.
// - Combined counter reset does both sides.
// - Main divider restarts aligned with reference divider.
// - Gain boost pulls status pin to ground.
// - Gain boost follows the written gain bit.
// - Each side powers down sync or async.
// - IF sleep with pump-float clear: synchronous.
// - Synchronous: pump floats first, then power-down.
// - Two low bits select latch; 11 is RF.
// - Sleep with float set: down at strobe.
// - Power-down forces dividers into load state.
// - Serial port keeps latching while powered down.
package prdmc_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W         = 24;
  localparam logic [1:0]  SEL_IF_REF     = 2'h0;
  localparam logic [1:0]  SEL_IF_MAIN    = 2'h1;
  localparam logic [1:0]  SEL_RF_REF     = 2'h2;
  localparam logic [1:0]  SEL_RF_MAIN    = 2'h3;
  localparam int unsigned MUX_SEL_POS    = 20;
  localparam int unsigned PUMP_FLOAT_POS = 16;
  localparam int unsigned IF_SLEEP_POS   = 22;
  localparam logic [23:0] WORD_RST       = 24'h000000;
  localparam logic [3:0]  MUX_SEL_RST    = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PD_DRAIN_NS    = 100;
  localparam int unsigned PD_DRAIN_CYC   = (PD_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  PD_DRAIN_LAST  = 8'(PD_DRAIN_CYC - 1);
  localparam logic [7:0]  CNT_RST        = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rf_gain_boost_bit;
    logic        rf_sleep_bit;
    logic        rf_prescale_sel_hi;
    logic        rf_prescale_sel_lo;
    logic [11:0] main_count;
    logic [5:0]  swallow_count;
    logic        latch_sel_hi;
    logic        latch_sel_lo;
  } prdmc_rf_word_t;

  typedef enum logic [3:0] {
    MUX_LOW, MUX_IF_ALOCK, MUX_RF_ALOCK, MUX_RFIF_ALOCK, MUX_HIGH,
    MUX_THREE_STATE, MUX_IF_CNT_RST, MUX_RF_CNT_RST, MUX_RFIF_CNT_RST
  } prdmc_mux_t;

  typedef enum logic [1:0] {PD_UP, PD_DRAIN, PD_DOWN} prdmc_pd_state_t;

  typedef struct packed {
    logic pump_hiz;
    logic counter_load;
    logic powered_down;
  } prdmc_pd_out_t;

endpackage

// ---- rtl/prdmc_pd_seq.sv ----
module prdmc_pd_seq (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Latched control bits
  input  wire logic              sleep_bit,
  input  wire logic              pump_float_bit,
  // Sequencer outputs
  output prdmc_pkg::prdmc_pd_out_t pd_out
);
  import prdmc_pkg::*;

  typedef struct packed {
    prdmc_pd_state_t state;
    logic [7:0]      cnt;
    prdmc_pd_out_t   outs;
  } prdmc_pd_reg_t;

  prdmc_pd_reg_t st_ff;
  prdmc_pd_reg_t nxt_st;

  // ----------------------------------------------------------------
  // Power-down sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.state)
      PD_UP: begin
        if (sleep_bit && pump_float_bit) begin
          nxt_st.state = PD_DOWN;
        end else if (sleep_bit) begin
          nxt_st.state = PD_DRAIN;
          nxt_st.cnt   = PD_DRAIN_LAST;
        end
      end
      PD_DRAIN: begin
        if (!sleep_bit) begin
          nxt_st.state = PD_UP;
        end else if (st_ff.cnt == CNT_RST) begin
          nxt_st.state = PD_DOWN;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      PD_DOWN: begin
        if (!sleep_bit) begin
          nxt_st.state = PD_UP;
        end
      end
    endcase
    nxt_st.outs.pump_hiz     = nxt_st.state != PD_UP;
    nxt_st.outs.counter_load = nxt_st.state != PD_UP;
    nxt_st.outs.powered_down = nxt_st.state == PD_DOWN;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '{state: PD_UP, cnt: CNT_RST, outs: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pd_out = st_ff.outs;

endmodule // prdmc_pd_seq

// ---- rtl/prdmc_top.sv ----
module prdmc_top (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Three-wire serial port
  input  wire logic                  sclk,
  input  wire logic                  sdata,
  input  wire logic                  load_strobe,
  // Phase detector activity, high while a correction pulse is out
  input  wire logic                  if_pfd_busy,
  input  wire logic                  rf_pfd_busy,
  // Status pin
  output logic                       mux_status_out,
  output logic                       mux_status_oe,
  // Decoded RF main-divider word
  output prdmc_pkg::prdmc_rf_word_t  rf_word,
  output logic                       rf_gain_boost,
  // Section control
  output logic                       if_pump_hiz,
  output logic                       rf_pump_hiz,
  output logic                       if_counter_load,
  output logic                       rf_counter_load,
  output logic                       if_powered_down,
  output logic                       rf_powered_down
);
  import prdmc_pkg::*;

  typedef struct packed {
    logic [4:0]     sync1;
    logic [4:0]     sync2;
    logic           sclk_prev;
    logic           le_prev;
    logic [23:0]    shift;
    logic [3:0]     mux_sel;
    logic           if_pump_float_bit;
    logic           if_sleep_bit;
    logic           rf_pump_float_bit;
    prdmc_rf_word_t rf_n;
    logic           status_out;
    logic           status_oe;
    logic           boost;
    logic           if_hiz;
    logic           rf_hiz;
    logic           if_load;
    logic           rf_load;
    logic           if_down;
    logic           rf_down;
  } prdmc_state_t;

  prdmc_state_t  st_ff;
  prdmc_state_t  nxt_st;
  prdmc_pd_out_t if_pd;
  prdmc_pd_out_t rf_pd;

  // ----------------------------------------------------------------
  // Power-down sequencers
  // ----------------------------------------------------------------
  prdmc_pd_seq u_if_pd (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .sleep_bit      (st_ff.if_sleep_bit),
    .pump_float_bit (st_ff.if_pump_float_bit),
    .pd_out         (if_pd)
  );

  prdmc_pd_seq u_rf_pd (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .sleep_bit      (st_ff.rf_n.rf_sleep_bit),
    .pump_float_bit (st_ff.rf_pump_float_bit),
    .pd_out         (rf_pd)
  );

  // ----------------------------------------------------------------
  // Serial port, latches and status logic
  // ----------------------------------------------------------------
  always_comb begin
    logic       sclk_s;
    logic       sdata_s;
    logic       le_s;
    logic       if_lock;
    logic       rf_lock;
    logic       if_rst_mode;
    logic       rf_rst_mode;
    prdmc_mux_t mode;
    nxt_st      = st_ff;
    nxt_st.sync1 = {rf_pfd_busy, if_pfd_busy, load_strobe, sdata, sclk};
    nxt_st.sync2 = st_ff.sync1;
    sclk_s      = st_ff.sync2[0];
    sdata_s     = st_ff.sync2[1];
    le_s        = st_ff.sync2[2];
    if_lock     = !st_ff.sync2[3];
    rf_lock     = !st_ff.sync2[4];
    mode        = prdmc_mux_t'(st_ff.mux_sel);
    if_rst_mode = (mode == MUX_IF_CNT_RST) || (mode == MUX_RFIF_CNT_RST);
    rf_rst_mode = (mode == MUX_RF_CNT_RST) || (mode == MUX_RFIF_CNT_RST);
    nxt_st.sclk_prev = sclk_s;
    nxt_st.le_prev   = le_s;
    // Shifting and latching never depend on power-down state.
    if (sclk_s && !st_ff.sclk_prev) begin
      nxt_st.shift = {st_ff.shift[22:0], sdata_s};
    end
    if (le_s && !st_ff.le_prev) begin
      unique case (st_ff.shift[1:0])
        SEL_IF_REF: begin
          nxt_st.mux_sel           = st_ff.shift[MUX_SEL_POS +: 4];
          nxt_st.if_pump_float_bit = st_ff.shift[PUMP_FLOAT_POS];
        end
        SEL_IF_MAIN: begin
          nxt_st.if_sleep_bit = st_ff.shift[IF_SLEEP_POS];
        end
        SEL_RF_REF: begin
          nxt_st.rf_pump_float_bit = st_ff.shift[PUMP_FLOAT_POS];
        end
        SEL_RF_MAIN: begin
          nxt_st.rf_n = prdmc_rf_word_t'(st_ff.shift);
        end
      endcase
    end
    nxt_st.boost   = st_ff.rf_n.rf_gain_boost_bit;
    nxt_st.if_hiz  = if_rst_mode || st_ff.if_pump_float_bit || if_pd.pump_hiz;
    nxt_st.rf_hiz  = rf_rst_mode || st_ff.rf_pump_float_bit || rf_pd.pump_hiz;
    // Both dividers of a loop share one load term, so they leave it together.
    nxt_st.if_load = if_rst_mode || if_pd.counter_load;
    nxt_st.rf_load = rf_rst_mode || rf_pd.counter_load;
    nxt_st.if_down = if_pd.powered_down;
    nxt_st.rf_down = rf_pd.powered_down;
    nxt_st.status_oe = 1'b1;
    if (st_ff.rf_n.rf_gain_boost_bit) begin
      nxt_st.status_out = 1'b0;
    end else begin
      unique case (mode)
        MUX_IF_ALOCK:    nxt_st.status_out = if_lock;
        MUX_RF_ALOCK:    nxt_st.status_out = rf_lock;
        MUX_RFIF_ALOCK:  nxt_st.status_out = if_lock && rf_lock;
        MUX_HIGH:        nxt_st.status_out = 1'b1;
        MUX_THREE_STATE: begin
          nxt_st.status_out = 1'b0;
          nxt_st.status_oe  = 1'b0;
        end
        default:         nxt_st.status_out = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff         <= '0;
      st_ff.shift   <= WORD_RST;
      st_ff.mux_sel <= MUX_SEL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mux_status_out  = st_ff.status_out;
  assign mux_status_oe   = st_ff.status_oe;
  assign rf_word         = st_ff.rf_n;
  assign rf_gain_boost   = st_ff.boost;
  assign if_pump_hiz     = st_ff.if_hiz;
  assign rf_pump_hiz     = st_ff.rf_hiz;
  assign if_counter_load = st_ff.if_load;
  assign rf_counter_load = st_ff.rf_load;
  assign if_powered_down = st_ff.if_down;
  assign rf_powered_down = st_ff.rf_down;

endmodule // prdmc_top

// ---- tb/prdmc_host.sv ----
module prdmc_host (
  // Clock
  input  wire logic clk_sys,
  // Serial pins
  output logic      sclk,
  output logic      sdata,
  output logic      load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk        = 1'b0;
    sdata       = 1'b0;
    load_strobe = 1'b0;
  end

  // ----------------------------------------------------------------
  // Word transfer
  // ----------------------------------------------------------------
  // The clock stands low between frames; data is inverted once released.
  // One serial clock period is 16 system clocks, 160 ns.
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata <= w[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    sdata <= ~w[0];
    repeat (4) @(posedge clk_sys);
    load_strobe <= 1'b1;
    repeat (8) @(posedge clk_sys);
    load_strobe <= 1'b0;
  endtask
endmodule  // prdmc_host

// ---- tb/prdmc_top_asserts.sv ----
module prdmc_asserts (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst,
  // Watched outputs
  input wire logic                     mux_status_out,
  input wire logic                     mux_status_oe,
  input wire prdmc_pkg::prdmc_rf_word_t rf_word,
  input wire logic                     rf_gain_boost,
  input wire logic                     if_pump_hiz,
  input wire logic                     rf_pump_hiz,
  input wire logic                     if_counter_load,
  input wire logic                     rf_counter_load,
  input wire logic                     if_powered_down,
  input wire logic                     rf_powered_down
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  boost_pin_low_a: assert property (
    rf_gain_boost && $past(rf_gain_boost) |-> mux_status_oe && !mux_status_out)
    else $error("pin not grounded in boost");
  boost_follow_a: assert property (
    $stable(rf_word) [*3] |-> rf_gain_boost == rf_word.rf_gain_boost_bit)
    else $error("boost differs from bit");
  rf_pd_hiz_a: assert property (
    $rose(rf_powered_down) |-> $past(rf_pump_hiz))
    else $error("rf down before pump float");
  if_pd_hiz_a: assert property (
    $rose(if_powered_down) |-> $past(if_pump_hiz))
    else $error("if down before pump float");
  rf_pd_load_a: assert property (
    rf_powered_down |-> rf_counter_load)
    else $error("rf down without load");
  if_pd_load_a: assert property (
    if_powered_down |-> if_counter_load)
    else $error("if down without load");
  rf_load_hiz_a: assert property (
    rf_counter_load |-> rf_pump_hiz)
    else $error("rf load without float");
  if_load_hiz_a: assert property (
    if_counter_load |-> if_pump_hiz)
    else $error("if load without float");
  if_drain_wait_a: assert property (
    $rose(if_counter_load) && !if_powered_down |-> !if_powered_down [*8])
    else $error("if down too early");
endmodule  // prdmc_asserts

bind prdmc_top prdmc_asserts prdmc_asserts_inst (
  .clk_sys         (clk_sys),
  .rst             (rst),
  .mux_status_out  (mux_status_out),
  .mux_status_oe   (mux_status_oe),
  .rf_word         (rf_word),
  .rf_gain_boost   (rf_gain_boost),
  .if_pump_hiz     (if_pump_hiz),
  .rf_pump_hiz     (rf_pump_hiz),
  .if_counter_load (if_counter_load),
  .rf_counter_load (rf_counter_load),
  .if_powered_down (if_powered_down),
  .rf_powered_down (rf_powered_down)
);

// ---- tb/test_pll_rf_divider_mode_control.sv ----
module test_pll_rf_divider_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import prdmc_pkg::*;

  logic clk_sys, rst, if_pfd_busy, rf_pfd_busy, sclk, sdata, load_strobe;
  logic mux_status_out, mux_status_oe, rf_gain_boost, if_pump_hiz, rf_pump_hiz;
  logic if_counter_load, rf_counter_load, if_powered_down, rf_powered_down;
  prdmc_rf_word_t rf_word;
  logic [23:0]    w;
  int             seed = 32'he0a4;
  int             fails = 0;
  int             n_compared = 0;
  int             cycles = 0;

  prdmc_top prdmc_top_inst (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .sclk            (sclk),
    .sdata           (sdata),
    .load_strobe     (load_strobe),
    .if_pfd_busy     (if_pfd_busy),
    .rf_pfd_busy     (rf_pfd_busy),
    .mux_status_out  (mux_status_out),
    .mux_status_oe   (mux_status_oe),
    .rf_word         (rf_word),
    .rf_gain_boost   (rf_gain_boost),
    .if_pump_hiz     (if_pump_hiz),
    .rf_pump_hiz     (rf_pump_hiz),
    .if_counter_load (if_counter_load),
    .rf_counter_load (rf_counter_load),
    .if_powered_down (if_powered_down),
    .rf_powered_down (rf_powered_down)
  );
  prdmc_host prdmc_host_inst (
    .clk_sys     (clk_sys),
    .sclk        (sclk),
    .sdata       (sdata),
    .load_strobe (load_strobe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected {drive enable, level} of the status pin for one mode.
  function automatic logic [1:0] exp_mux(input logic [3:0] c, input logic ib, rb);
    case (c)
      4'h1: return {1'b1, !ib};
      4'h2: return {1'b1, !rb};
      4'h3: return {1'b1, !ib && !rb};
      4'h4: return 2'h3;
      4'h5: return 2'h0;
      default: return 2'h2;
    endcase
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    if_pfd_busy = 1'b0;
    rf_pfd_busy = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("rf_word_rst", rf_word, 24'h000000);
    check("pd_rst", {if_powered_down, rf_powered_down, if_pump_hiz, rf_pump_hiz}, 4'h0);
    prdmc_host_inst.send(24'h400000);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 24'hffffff : (i == 1) ? 24'h000303 : 24'($random(seed));
      w[1:0] = 2'h3;
      prdmc_host_inst.send(w);
      repeat (20) @(posedge clk_sys);
      check("rf_word", rf_word, w);
      check("boost", rf_gain_boost, w[23]);
      check("pin", {mux_status_oe, mux_status_out}, w[23] ? 2'h2 : 2'h3);
      check("rf_down", {rf_pump_hiz, rf_powered_down}, {2{w[22]}});
    end
    prdmc_host_inst.send(24'hfefffe);
    check("rf_word_kept", rf_word, w);
    // Clear boost and sleep left by the random words before the status modes.
    prdmc_host_inst.send(24'h000003);
    check("rf_word_clr", rf_word, 24'h000003);
    for (int c = 0; c < 9; c++) begin
      prdmc_host_inst.send({c[3:0], 20'h0});
      repeat (4) begin
        if_pfd_busy <= 1'($random(seed));
        rf_pfd_busy <= 1'($random(seed));
        repeat (8) @(posedge clk_sys);
        check("mux_pin", {mux_status_oe, mux_status_oe & mux_status_out},
              exp_mux(c[3:0], if_pfd_busy, rf_pfd_busy));
        check("if_reset", {if_pump_hiz, if_counter_load}, {2{c == 6 || c == 8}});
        check("rf_reset", {rf_pump_hiz, rf_counter_load}, {2{c == 7 || c == 8}});
      end
    end
    prdmc_host_inst.send(24'h000000);
    prdmc_host_inst.send(24'h400001);
    check("if_sync", {if_pump_hiz, if_powered_down}, 2'h2);
    repeat (12) @(posedge clk_sys);
    check("if_down", {if_counter_load, if_powered_down}, 2'h3);
    prdmc_host_inst.send(24'h000001);
    prdmc_host_inst.send(24'h010000);
    prdmc_host_inst.send(24'h400001);
    check("if_async", if_powered_down, 1'b1);
    prdmc_host_inst.send(24'h000303);
    check("rf_word_pd", rf_word, 24'h000303);
    prdmc_host_inst.send(24'h000001);
    check("if_up", if_powered_down, 1'b0);
    summarize;
  end
endmodule  // test_pll_rf_divider_mode_control
